//--- design/mod_pkg.sv
// package for the opcode decoder and cycle sequencer
// assumes one 10 MHz core clock and an active-low asynchronous reset
package mod_pkg;
    // ****************************************
    // operation codes presented to the datapath
    // ****************************************
    typedef enum logic [5:0] {
        MOD_OP_HALT, MOD_OP_ADD, MOD_OP_ADC, MOD_OP_SUB, MOD_OP_SUB_BRW, MOD_OP_OR, MOD_OP_AND,
        MOD_OP_XOR, MOD_OP_CMP, MOD_OP_LDA, MOD_OP_LDX, MOD_OP_RSVD, MOD_OP_PAGE_ADV,
        MOD_OP_X2A, MOD_OP_A2X, MOD_OP_LD_PSTK, MOD_OP_CALL, MOD_OP_JMP, MOD_OP_JZ,
        MOD_OP_JMP_NZERO, MOD_OP_JC, MOD_OP_JMP_NCARRY, MOD_OP_JMP_ACC, MOD_OP_TABLE, MOD_OP_NOP,
        MOD_OP_INC, MOD_OP_DEC, MOD_OP_PORT_RD, MOD_OP_PORT_WR, MOD_OP_PORT_WRX,
        MOD_OP_POP, MOD_OP_PUSH, MOD_OP_SWAP_X, MOD_OP_SWAP_DSP, MOD_OP_STA, MOD_OP_RMW_OR,
        MOD_OP_RMW_AND, MOD_OP_RMW_XOR, MOD_OP_COMPL, MOD_OP_ASL, MOD_OP_ASR, MOD_OP_ROT_LC,
        MOD_OP_ROT_RC, MOD_OP_RET, MOD_OP_RET_INTR, MOD_OP_INTR_DIS, MOD_OP_EI
    } mod_op_e;

    // operand form: none, immediate, direct, indexed, accumulator, index reg, address
    typedef enum logic [2:0] {
        MOD_AM_NONE, MOD_AM_IMM, MOD_AM_DIR, MOD_AM_IDX, MOD_AM_ACC, MOD_AM_X, MOD_AM_ADDR
    } mod_am_e;

    // ****************************************
    // sequencer states
    // ****************************************
    typedef enum logic [2:0] {
        MOD_ST_FETCH = 3'b001,
        MOD_ST_EXEC  = 3'b010,
        MOD_ST_HALT  = 3'b100
    } mod_st_e;

    localparam int unsigned MOD_CLK_HZ    = 10000000;
    localparam logic [3:0]  MOD_CYC_W0    = 4'h0;
    localparam logic [3:0]  MOD_CYC_ONE   = 4'h1;
    localparam logic [7:0]  MOD_ONE8      = 8'h01;
    localparam logic [7:0]  MOD_TWO8      = 8'h02;
    localparam logic [7:0]  MOD_ZERO8     = 8'h00;
    localparam logic [13:0] MOD_PC_RST    = 14'h0000;
    localparam logic [5:0]  MOD_PAGE_ONE  = 6'h01;
    localparam logic [3:0]  MOD_PAGE_POS  = 4'h8;
endpackage : mod_pkg

//--- design/mod_decoder.sv
// opcode decoder and cycle sequencer for the 8-bit core
// assumes program memory answers combinationally to PMEM_ADDR; datapath obeys OP_* pulses
`timescale 1ns/1ps
`default_nettype none
module mod_decoder
    import mod_pkg::*;
#(
    parameter int unsigned CYC_W = 4
) (
    input  wire logic              CLK,
    input  wire logic              ARST_N,
    input  wire logic [7:0]        PMEM_DATA,
    input  wire logic [7:0]        X_REG,
    input  wire logic              ZERO_FLAG,
    input  wire logic              CARRY_FLAG,
    input  wire logic              INTR_REQ,
    output logic      [13:0]       PMEM_ADDR,
    output logic                   FETCH,
    output logic                   OP_START,
    output logic                   OP_DONE,
    output mod_pkg::mod_op_e       OP_CODE,
    output mod_pkg::mod_am_e       OP_MODE,
    output logic      [7:0]        OPERAND,
    output logic      [7:0]        EFF_ADDR,
    output logic      [13:0]       TARGET,
    output logic                   BRANCH_TAKEN,
    output logic      [7:0]        PSTK_DELTA,
    output logic                   PSTK_UP,
    output logic                   DSP_PRE_DEC,
    output logic                   DSP_POST_INC,
    output logic                   RESTORE_FLAGS,
    output logic                   INTR_EN,
    output logic                   HALTED,
    output logic                   ILLEGAL
);
    import mod_pkg::*;

    // ****************************************
    // combinational decode of one opcode byte
    // ****************************************
    mod_op_e            dec_op;
    mod_am_e            dec_am;
    logic [CYC_W-1:0]   dec_cyc;
    logic               dec_two;

    function automatic mod_am_e am3(input logic [1:0] k);
        am3 = (k == 2'd0) ? MOD_AM_IMM : (k == 2'd1) ? MOD_AM_DIR : MOD_AM_IDX;
    endfunction

    always_comb begin
        logic [1:0] k;
        k       = 2'd0;
        dec_op  = MOD_OP_RSVD;
        dec_am  = MOD_AM_NONE;
        dec_cyc = CYC_W'(4);
        dec_two = 1'b0;
        if (PMEM_DATA == 8'h00) begin
            dec_op  = MOD_OP_HALT;
            dec_cyc = CYC_W'(7);
        end else if (PMEM_DATA <= 8'h15) begin
            k       = 2'(({24'h0, PMEM_DATA} - 32'd1) % 32'd3);
            dec_am  = am3(k);
            dec_cyc = (k == 2'd0) ? CYC_W'(4) : (k == 2'd1) ? CYC_W'(6) : CYC_W'(7);
            dec_two = 1'b1;
            case (3'(({24'h0, PMEM_DATA} - 32'd1) / 32'd3))
                3'd0: dec_op = MOD_OP_ADD;
                3'd1: dec_op = MOD_OP_ADC;
                3'd2: dec_op = MOD_OP_SUB;
                3'd3: dec_op = MOD_OP_SUB_BRW;
                3'd4: dec_op = MOD_OP_OR;
                3'd5: dec_op = MOD_OP_AND;
                3'd6: dec_op = MOD_OP_XOR;
                default: dec_op = MOD_OP_RSVD;
            endcase
        end else if (PMEM_DATA[7:4] == 4'h5 || PMEM_DATA[7:4] == 4'h9) begin
            dec_op = MOD_OP_CALL; dec_am = MOD_AM_ADDR;
            dec_cyc = CYC_W'(10); dec_two = 1'b1;
        end else if (PMEM_DATA[7] && PMEM_DATA[7:4] != 4'h9) begin
            dec_am = MOD_AM_ADDR; dec_two = 1'b1; dec_cyc = CYC_W'(5);
            case (PMEM_DATA[7:4])
                4'h8: dec_op = MOD_OP_JMP;
                4'ha: dec_op = MOD_OP_JZ;
                4'hb: dec_op = MOD_OP_JMP_NZERO;
                4'hc: dec_op = MOD_OP_JC;
                4'hd: dec_op = MOD_OP_JMP_NCARRY;
                4'he: begin dec_op = MOD_OP_JMP_ACC; dec_cyc = CYC_W'(7); end
                default: begin dec_op = MOD_OP_TABLE; dec_cyc = CYC_W'(14); end
            endcase
        end else begin
            case (PMEM_DATA)
                8'h16: begin dec_op = MOD_OP_CMP; dec_am = MOD_AM_IMM; dec_cyc = CYC_W'(5); end
                8'h17: begin dec_op = MOD_OP_CMP; dec_am = MOD_AM_DIR; dec_cyc = CYC_W'(7); end
                8'h18: begin dec_op = MOD_OP_CMP; dec_am = MOD_AM_IDX; dec_cyc = CYC_W'(8); end
                8'h19: begin dec_op = MOD_OP_LDA; dec_am = MOD_AM_IMM; end
                8'h1a: begin dec_op = MOD_OP_LDA; dec_am = MOD_AM_DIR; dec_cyc = CYC_W'(5); end
                8'h1b: begin dec_op = MOD_OP_LDA; dec_am = MOD_AM_IDX; dec_cyc = CYC_W'(6); end
                8'h1c: begin dec_op = MOD_OP_LDX; dec_am = MOD_AM_IMM; end
                8'h1d: begin dec_op = MOD_OP_LDX; dec_am = MOD_AM_DIR; dec_cyc = CYC_W'(5); end
                8'h1f: dec_op = MOD_OP_PAGE_ADV;
                8'h40: dec_op = MOD_OP_X2A;
                8'h41: dec_op = MOD_OP_A2X;
                8'h60: dec_op = MOD_OP_LD_PSTK;
                8'h20: dec_op = MOD_OP_NOP;
                8'h21: begin dec_op = MOD_OP_INC; dec_am = MOD_AM_ACC; end
                8'h22: begin dec_op = MOD_OP_INC; dec_am = MOD_AM_X; end
                8'h23: begin dec_op = MOD_OP_INC; dec_am = MOD_AM_DIR; dec_cyc = CYC_W'(7); end
                8'h24: begin dec_op = MOD_OP_INC; dec_am = MOD_AM_IDX; dec_cyc = CYC_W'(8); end
                8'h25: begin dec_op = MOD_OP_DEC; dec_am = MOD_AM_ACC; end
                8'h26: begin dec_op = MOD_OP_DEC; dec_am = MOD_AM_X; end
                8'h27: begin dec_op = MOD_OP_DEC; dec_am = MOD_AM_DIR; dec_cyc = CYC_W'(7); end
                8'h28: begin dec_op = MOD_OP_DEC; dec_am = MOD_AM_IDX; dec_cyc = CYC_W'(8); end
                8'h29: begin dec_op = MOD_OP_PORT_RD; dec_am = MOD_AM_DIR; dec_cyc = CYC_W'(5); end
                8'h2a: begin dec_op = MOD_OP_PORT_WR; dec_am = MOD_AM_DIR; dec_cyc = CYC_W'(5); end
                8'h39: begin dec_op = MOD_OP_PORT_WRX; dec_am = MOD_AM_IDX; dec_cyc = CYC_W'(6); end
                8'h2b: begin dec_op = MOD_OP_POP; dec_am = MOD_AM_ACC; end
                8'h2c: begin dec_op = MOD_OP_POP; dec_am = MOD_AM_X; end
                8'h2d: begin dec_op = MOD_OP_PUSH; dec_am = MOD_AM_ACC; dec_cyc = CYC_W'(5); end
                8'h2e: begin dec_op = MOD_OP_PUSH; dec_am = MOD_AM_X; dec_cyc = CYC_W'(5); end
                8'h2f: begin dec_op = MOD_OP_SWAP_X; dec_cyc = CYC_W'(5); end
                8'h30: begin dec_op = MOD_OP_SWAP_DSP; dec_cyc = CYC_W'(5); end
                8'h31: begin dec_op = MOD_OP_STA; dec_am = MOD_AM_DIR; dec_cyc = CYC_W'(5); end
                8'h32: begin dec_op = MOD_OP_STA; dec_am = MOD_AM_IDX; dec_cyc = CYC_W'(6); end
                8'h33, 8'h34: dec_op = MOD_OP_RMW_OR;
                8'h35, 8'h36: dec_op = MOD_OP_RMW_AND;
                8'h37, 8'h38: dec_op = MOD_OP_RMW_XOR;
                8'h3a: dec_op = MOD_OP_COMPL;
                8'h3b: dec_op = MOD_OP_ASL;
                8'h3c: dec_op = MOD_OP_ASR;
                8'h3d: dec_op = MOD_OP_ROT_LC;
                8'h3e: dec_op = MOD_OP_ROT_RC;
                8'h3f: begin dec_op = MOD_OP_RET; dec_cyc = CYC_W'(8); end
                8'h73: begin dec_op = MOD_OP_RET_INTR; dec_cyc = CYC_W'(8); end
                8'h70: dec_op = MOD_OP_INTR_DIS;
                8'h72: dec_op = MOD_OP_EI;
                default: dec_op = MOD_OP_RSVD;
            endcase
            if (PMEM_DATA >= 8'h33 && PMEM_DATA <= 8'h38) begin
                dec_am  = PMEM_DATA[0] ? MOD_AM_DIR : MOD_AM_IDX;
                dec_cyc = PMEM_DATA[0] ? CYC_W'(7) : CYC_W'(8);
            end
            dec_two = (dec_am == MOD_AM_IMM) || (dec_am == MOD_AM_DIR) || (dec_am == MOD_AM_IDX);
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    mod_st_e            st_q;
    logic [CYC_W-1:0]   cnt_q;
    logic [13:0]        pc_q;
    logic [3:0]         nib_q;
    logic               two_q;
    logic               ie_q;
    logic               last;

    assign last = (st_q == MOD_ST_EXEC) && (cnt_q == CYC_W'(MOD_CYC_ONE));
    assign FETCH = (st_q == MOD_ST_FETCH);
    assign PMEM_ADDR = pc_q;
    assign OP_DONE = last;
    assign HALTED = (st_q == MOD_ST_HALT);
    assign INTR_EN = ie_q;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_q     <= MOD_ST_FETCH;
            cnt_q    <= CYC_W'(MOD_CYC_W0);
            OP_START <= 1'b0;
            OP_CODE  <= MOD_OP_NOP;
            OP_MODE  <= MOD_AM_NONE;
            ILLEGAL  <= 1'b0;
            nib_q    <= 4'h0;
            two_q    <= 1'b0;
        end else begin
            OP_START <= 1'b0;
            case (st_q)
                MOD_ST_FETCH: begin
                    st_q     <= MOD_ST_EXEC;
                    cnt_q    <= dec_cyc - CYC_W'(MOD_CYC_ONE);
                    OP_START <= 1'b1;
                    OP_CODE  <= dec_op;
                    OP_MODE  <= dec_am;
                    ILLEGAL  <= (dec_op == MOD_OP_RSVD);
                    nib_q    <= PMEM_DATA[3:0];
                    two_q    <= dec_two;
                end
                MOD_ST_EXEC: begin
                    cnt_q <= cnt_q - CYC_W'(MOD_CYC_ONE);
                    if (last)
                        st_q <= (OP_CODE == MOD_OP_HALT) ? MOD_ST_HALT : MOD_ST_FETCH;
                end
                MOD_ST_HALT: st_q <= MOD_ST_HALT;
                default: st_q <= MOD_ST_FETCH;
            endcase
        end
    end

    // operand byte captured on the cycle after the opcode
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pc_q    <= MOD_PC_RST;
            OPERAND <= MOD_ZERO8;
        end else if (FETCH) begin
            pc_q[7:0] <= pc_q[7:0] + MOD_ONE8;
        end else if (OP_START && two_q) begin
            OPERAND   <= PMEM_DATA;
            pc_q[7:0] <= pc_q[7:0] + MOD_ONE8;
        end else if (last && OP_CODE == MOD_OP_PAGE_ADV) begin
            pc_q[13:8] <= pc_q[13:8] + MOD_PAGE_ONE;
            pc_q[7:0]  <= MOD_ZERO8;
        end else if (last && BRANCH_TAKEN) begin
            pc_q <= TARGET;
        end
    end

    // ****************************************
    // address formation and stack control
    // ****************************************
    always_comb begin
        TARGET   = {2'b00, nib_q, OPERAND};
        EFF_ADDR = (OP_MODE == MOD_AM_IDX) ? 8'(OPERAND + X_REG) : OPERAND;
        BRANCH_TAKEN = 1'b0;
        case (OP_CODE)
            MOD_OP_JMP, MOD_OP_CALL: BRANCH_TAKEN = 1'b1;
            MOD_OP_JZ:         BRANCH_TAKEN = ZERO_FLAG;
            MOD_OP_JMP_NZERO:  BRANCH_TAKEN = !ZERO_FLAG;
            MOD_OP_JC:         BRANCH_TAKEN = CARRY_FLAG;
            MOD_OP_JMP_NCARRY: BRANCH_TAKEN = !CARRY_FLAG;
            default:           BRANCH_TAKEN = 1'b0;
        endcase
        PSTK_DELTA    = (OP_CODE == MOD_OP_CALL || OP_CODE == MOD_OP_RET
                         || OP_CODE == MOD_OP_RET_INTR || INTR_REQ) ? MOD_TWO8 : MOD_ZERO8;
        PSTK_UP       = (OP_CODE == MOD_OP_CALL) || INTR_REQ;
        RESTORE_FLAGS = (OP_CODE == MOD_OP_RET_INTR);
        DSP_PRE_DEC   = (OP_CODE == MOD_OP_PUSH);
        DSP_POST_INC  = (OP_CODE == MOD_OP_POP);
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N)
            ie_q <= 1'b0;
        else if (last && (OP_CODE == MOD_OP_EI || OP_CODE == MOD_OP_RET_INTR))
            ie_q <= 1'b1;
        else if ((last && OP_CODE == MOD_OP_INTR_DIS) || (INTR_REQ && ie_q))
            ie_q <= 1'b0;
    end

    // ****************************************
    // checks
    // ****************************************
    AST_HALT_SEVEN: assert property (@(posedge CLK) disable iff (!ARST_N)
        OP_START && OP_CODE == MOD_OP_HALT |-> ##5 (last && HALTED == 1'b0) ##1 HALTED)
        else $error("halt did not take seven cycles");
    AST_CALL_TEN: assert property (@(posedge CLK) disable iff (!ARST_N)
        OP_START && OP_CODE == MOD_OP_CALL |-> !last [*8] ##1 last)
        else $error("call did not take ten cycles");
    AST_TABLE_FOURTEEN: assert property (@(posedge CLK) disable iff (!ARST_N)
        OP_START && OP_CODE == MOD_OP_TABLE |-> ##12 last)
        else $error("table index did not take fourteen cycles");
    AST_FETCH_AFTER: assert property (@(posedge CLK) disable iff (!ARST_N)
        FETCH |-> ##1 (!FETCH && OP_START))
        else $error("fetch not followed by start");
    AST_JMP_FIVE: assert property (@(posedge CLK) disable iff (!ARST_N)
        OP_START && OP_CODE == MOD_OP_JMP |-> ##3 last ##1 (FETCH && PMEM_ADDR == $past(TARGET)))
        else $error("jump did not land on its target in five cycles");
    AST_ACCUMULATOR_OFFSET_JUMP_SEVEN: assert property (@(posedge CLK) disable iff (!ARST_N)
        OP_START && OP_CODE == MOD_OP_JMP_ACC |-> ##5 last)
        else $error("accumulator jump not seven cycles");
    AST_IDX_ADDR: assert property (@(posedge CLK) disable iff (!ARST_N)
        OP_MODE == MOD_AM_IDX |-> EFF_ADDR == 8'(OPERAND + X_REG))
        else $error("indexed address wrong");
    AST_PAGE_ADV: assert property (@(posedge CLK) disable iff (!ARST_N)
        last && OP_CODE == MOD_OP_PAGE_ADV |=> PMEM_ADDR[13:8] == 6'($past(PMEM_ADDR[13:8]) + 6'h01))
        else $error("page advance did not bump upper bits");
    AST_INTR_RET_IE: assert property (@(posedge CLK) disable iff (!ARST_N)
        last && OP_CODE == MOD_OP_RET_INTR && !INTR_REQ |=> INTR_EN)
        else $error("interrupt return did not re-enable");
endmodule // mod_decoder
`default_nettype wire

//--- verification/mod_pmem_model.sv
// program memory model that feeds opcode bytes to the decoder
// assumes the bench loads bytes by hierarchical write into mem
`timescale 1ns/1ps
`default_nettype none
module mod_pmem_model (
    input  wire logic [13:0] addr,
    output logic      [7:0]  data
);
    logic [7:0] mem [0:16383];

    // answers combinationally; unwritten bytes read as no-operation
    assign data = mem[addr];

    initial begin
        for (int i = 0; i < 16384; i++) mem[i] = 8'h20;
    end
endmodule // mod_pmem_model
`default_nettype wire

//--- verification/mod_decoder_tb_top.sv
// self-checking bench for the opcode decoder and cycle sequencer
// assumes mod_pmem_model as program memory and a 10 MHz core clock
`timescale 1ns/1ps
`default_nettype none
module mod_decoder_tb_top;
    import mod_pkg::*;
    logic        CLK, ARST_N, ZERO_FLAG, CARRY_FLAG, INTR_REQ, FETCH, OP_DONE, PSTK_UP;
    logic        DSP_PRE_DEC, DSP_POST_INC, RESTORE_FLAGS, INTR_EN, HALTED, ILLEGAL;
    logic        OP_START, BRANCH_TAKEN;
    logic [7:0]  PMEM_DATA, X_REG, OPERAND, EFF_ADDR, PSTK_DELTA;
    logic [13:0] PMEM_ADDR, TARGET;
    mod_op_e     OP_CODE;
    mod_am_e     OP_MODE;
    int          bad_count = 0;
    int          comparisons = 0;

    mod_pmem_model i_pmem (.addr(PMEM_ADDR), .data(PMEM_DATA));
    mod_decoder #(.CYC_W(4)) i_dut (
        .CLK(CLK), .ARST_N(ARST_N), .PMEM_DATA(PMEM_DATA), .X_REG(X_REG),
        .ZERO_FLAG(ZERO_FLAG), .CARRY_FLAG(CARRY_FLAG), .INTR_REQ(INTR_REQ),
        .PMEM_ADDR(PMEM_ADDR), .FETCH(FETCH), .OP_START(OP_START), .OP_DONE(OP_DONE),
        .OP_CODE(OP_CODE), .OP_MODE(OP_MODE), .OPERAND(OPERAND), .EFF_ADDR(EFF_ADDR),
        .TARGET(TARGET), .BRANCH_TAKEN(BRANCH_TAKEN), .PSTK_DELTA(PSTK_DELTA),
        .PSTK_UP(PSTK_UP),
        .DSP_PRE_DEC(DSP_PRE_DEC), .DSP_POST_INC(DSP_POST_INC),
        .RESTORE_FLAGS(RESTORE_FLAGS), .INTR_EN(INTR_EN), .HALTED(HALTED),
        .ILLEGAL(ILLEGAL));

    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end

    // ****************************************
    // expected behaviour per opcode
    // ****************************************
    function automatic int n_cyc(input logic [7:0] o);
        string t;
        t = {"7467467467467467467467", "5784564544", "44478", "44785544555556787878", "6444448"};
        if (o < 8'h40) return t[o] - 8'h30;
        if (o inside {8'h40, 8'h41, 8'h60, 8'h70, 8'h72}) return 4;
        if (o == 8'h73) return 8;
        case (o[7:4])
            4'h5, 4'h9: return 10;
            4'h8, 4'ha, 4'hb, 4'hc, 4'hd: return 5;
            4'he: return 7;
            4'hf: return 14;
            default: return 4;
        endcase
    endfunction

    function automatic logic rsvd(input logic [7:0] o);
        if (o inside {8'h40, 8'h41, 8'h60, 8'h70, 8'h72, 8'h73}) return 1'b0;
        if (o[7:4] inside {4'h5, [4'h8:4'hf]}) return 1'b0;
        return (o == 8'h1e) || (o >= 8'h40);
    endfunction

    function automatic logic two_b(input logic [7:0] o);
        if (o < 8'h40) return o inside {[8'h01:8'h1d], 8'h23, 8'h24, [8'h27:8'h2a], [8'h31:8'h39]};
        return o[7:4] inside {4'h5, [4'h8:4'hf]};
    endfunction

    // next fetch address, or -1 on halt or where it depends on stack or accumulator
    function automatic int nxt(input logic [7:0] o, input logic z, input logic c);
        logic tk;
        tk = o[7:4] inside {4'h5, 4'h8, 4'h9} || (o[7:4] == 4'ha && z) ||
             (o[7:4] == 4'hb && !z) || (o[7:4] == 4'hc && c) || (o[7:4] == 4'hd && !c);
        if (o inside {8'h00, 8'h3f, 8'h73} || o >= 8'he0) return -1;
        if (o == 8'h1f) return 'h100;
        if (tk) return {o[3:0], 8'h5a};
        return two_b(o) ? 2 : 1;
    endfunction

    function automatic logic [11:0] ctl(input logic [7:0] o);
        logic cl;
        cl = o[7:4] inside {4'h5, 4'h9};
        return {(cl || o inside {8'h3f, 8'h73}) ? 8'h02 : 8'h00, cl,
                o inside {8'h2d, 8'h2e}, o inside {8'h2b, 8'h2c}, o == 8'h73};
    endfunction

    // expected operation: letters are offsets into the package's operation list, from MOD_OP_HALT below 8'h20 and from MOD_OP_NOP above
    function automatic logic [5:0] exp_op(input logic [7:0] o);
        string lo, hi;
        lo = {"abbbcccdddeeefffggghhh", "iiijjjkklm"};
        hi = "abbbbccccdegghhijkkllmmnnfopqrst";
        if (o < 8'h20) return 6'(lo[o] - 8'h61);
        if (o < 8'h40) return 6'(int'(MOD_OP_NOP) + hi[o - 8'h20] - 8'h61);
        case (o)
            8'h40: return MOD_OP_X2A;
            8'h41: return MOD_OP_A2X;
            8'h60: return MOD_OP_LD_PSTK;
            8'h70: return MOD_OP_INTR_DIS;
            8'h72: return MOD_OP_EI;
            8'h73: return MOD_OP_RET_INTR;
            default: ;
        endcase
        case (o[7:4])
            4'h5, 4'h9: return MOD_OP_CALL;
            4'h8: return MOD_OP_JMP;
            4'ha: return MOD_OP_JZ;
            4'hb: return MOD_OP_JMP_NZERO;
            4'hc: return MOD_OP_JC;
            4'hd: return MOD_OP_JMP_NCARRY;
            4'he: return MOD_OP_JMP_ACC;
            4'hf: return MOD_OP_TABLE;
            default: return MOD_OP_RSVD;
        endcase
    endfunction

    // expected operand form, digits in the order of the package's form list
    function automatic logic [2:0] exp_am(input logic [7:0] o);
        string t;
        t = {"0123123123123123123123", "1231231200", "04523452322454500232323233000000"};
        if (o < 8'h40) return 3'(t[o] - 8'h30);
        return (o[7:4] inside {4'h5, [4'h8:4'hf]}) ? 3'd6 : 3'd0;
    endfunction

    // ****************************************
    // checking and scenarios
    // ****************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic restart(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
        @(posedge CLK);
        #10 ARST_N = 1'b0;
        {i_pmem.mem[0], i_pmem.mem[1], i_pmem.mem[2]} = {b0, b1, b2};
        repeat (2) @(posedge CLK);
        #10 ARST_N = 1'b1;
    endtask

    task automatic wait_fetch(input logic [13:0] a);
        for (int k = 0; k < 30; k++) begin
            @(negedge CLK);
            if (FETCH === 1'b1 && PMEM_ADDR === a) break;
        end
        check({FETCH, PMEM_ADDR}, {1'b1, a});
    endtask

    // one opcode from reset: cycle count, controls, next fetch address
    task automatic run_op(input logic [7:0] o);
        int          n, starts;
        logic [11:0] got_c;
        logic [7:0]  got_op, got_ea;
        logic        got_il, got_br;
        logic [5:0]  got_oc;
        logic [2:0]  got_am;
        logic [13:0] got_tg;
        n = 0;
        starts = 0;
        restart(o, 8'h5a, 8'h20);
        @(negedge CLK);
        for (int k = 1; k <= 20 && n == 0; k++) begin
            @(negedge CLK);
            if (OP_START === 1'b1) starts++;
            if (OP_DONE === 1'b1) begin
                got_c = {PSTK_DELTA, PSTK_UP, DSP_PRE_DEC, DSP_POST_INC, RESTORE_FLAGS};
                {got_op, got_ea, got_il} = {OPERAND, EFF_ADDR, ILLEGAL};
                {got_oc, got_am, got_tg, got_br} = {OP_CODE, OP_MODE, TARGET, BRANCH_TAKEN};
            end
            if (FETCH === 1'b1) n = k;
        end
        check(n, o == 8'h00 ? 0 : n_cyc(o));
        check(starts, 1);
        check(got_oc, exp_op(o));
        check(got_am, exp_am(o));
        check(got_br, nxt(o, ZERO_FLAG, CARRY_FLAG) > 2 && o != 8'h1f);
        if (o[7:4] inside {4'h5, [4'h8:4'hf]}) check(got_tg, {2'b00, o[3:0], 8'h5a});
        check(got_c, ctl(o));
        check(got_il, rsvd(o));
        check(INTR_EN, o inside {8'h72, 8'h73});
        if (o == 8'h00) check(HALTED, 1);
        if (two_b(o)) check(got_op, 8'h5a);
        if (o == 8'h39) check(got_ea, 8'(8'h5a + X_REG));
        if (nxt(o, ZERO_FLAG, CARRY_FLAG) >= 0) check(PMEM_ADDR, nxt(o, ZERO_FLAG, CARRY_FLAG));
    endtask

    task automatic sweep(input logic z, input logic c, input logic [7:0] x);
        @(posedge CLK);
        #10 {ZERO_FLAG, CARRY_FLAG, X_REG} = {z, c, x};
        for (int i = 0; i < 256; i++) run_op(i[7:0]);
    endtask

    task automatic intr_seq;
        restart(8'h72, 8'h70, 8'h72);
        wait_fetch(14'h0001);
        check(INTR_EN, 1);
        wait_fetch(14'h0002);
        check(INTR_EN, 0);
        wait_fetch(14'h0003);
        check(INTR_EN, 1);
        @(posedge CLK);
        #10 INTR_REQ = 1'b1;
        @(negedge CLK);
        check({PSTK_DELTA, PSTK_UP}, {8'h02, 1'b1});
        @(posedge CLK);
        #10 INTR_REQ = 1'b0;
        @(negedge CLK);
        check(INTR_EN, 0);
    endtask

    initial begin
        {ARST_N, ZERO_FLAG, CARRY_FLAG, INTR_REQ, X_REG} = {4'h0, 8'h00};
        repeat (12) @(posedge CLK);
        #10 ARST_N = 1'b1;
        intr_seq();
        sweep(1'b0, 1'b0, 8'h30);
        sweep(1'b1, 1'b1, 8'hc0);
        report_and_stop();
    end

    // cuts a hang short well beyond the expected run length
    initial begin
        #3000000;
        bad_count++;
        report_and_stop();
    end
endmodule // mod_decoder_tb_top
`default_nettype wire
